// ==== hw/tpl_pkg.sv ====
// Purpose: Shared constants and types of the three-phase line fault supervisor
// Assumes: 100 MHz clock, voltages as unsigned volt codes
// Notes:   Timing counts derive from the clock period
package tpl_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS    = 1_000_000;
  localparam int TICK_CYCLES   = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int PRE_W         = 17;
  localparam int MS_W          = 15;
  // Trip delay range, 0.1 s to 20 s, held in ms
  localparam logic [MS_W-1:0] DELAY_MIN_MS = 15'h0064;
  localparam logic [MS_W-1:0] DELAY_MAX_MS = 15'h4E20;
  // Red indicator half period while flashing
  localparam logic [MS_W-1:0] FLASH_HALF_MS = 15'h00FA;
  // ----------------------------------------------------------------
  // Voltage thresholds
  // ----------------------------------------------------------------
  localparam int V_W = 10;
  localparam int P_W = 16;
  localparam logic [V_W-1:0] UN_MIN_V = 10'h0C8;
  localparam logic [V_W-1:0] UN_MAX_V = 10'h2B2;
  // Trip below 80 %: v*5 < un*4; recover at 85 % (80 % plus 5 % band): v*20 >= un*17
  localparam logic [P_W-1:0] TRIP_V_MUL  = 16'h0005;
  localparam logic [P_W-1:0] TRIP_UN_MUL = 16'h0004;
  localparam logic [P_W-1:0] REC_V_MUL   = 16'h0014;
  localparam logic [P_W-1:0] REC_UN_MUL  = 16'h0011;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       supply;
    logic       seq_ok;
    logic [2:0] phase_ok;
  } tpl_pins_t;

  typedef struct packed {
    logic [V_W-1:0] ab;
    logic [V_W-1:0] bc;
    logic [V_W-1:0] ca;
  } tpl_volts_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0]  ms;
    logic             expired;
  } tpl_timer_t;
endpackage

// ==== hw/tpl_ms_timer.sv ====
// Purpose: Millisecond timer that flags when a run of set length completes
// Assumes: run stays high for the whole interval
// Notes:   Dropping run clears the count and the flag
`timescale 1ns/10ps
`default_nettype none
module tpl_ms_timer #(
  parameter int TICK_CYCLES = tpl_pkg::TICK_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     run,
  input  wire logic [tpl_pkg::MS_W-1:0] limit_ms,
  output var  logic                     expired
);
  import tpl_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  tpl_timer_t t_reg;
  tpl_timer_t t_next;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_comb begin
    t_next = t_reg;
    if (!run) begin
      // Restart from zero so a later run gets the full delay
      t_next = '0;
    end else if (!t_reg.expired) begin
      if (t_reg.pre == PRE_LAST) begin
        t_next.pre = '0;
        if (t_reg.ms + 15'h0001 >= limit_ms) begin
          t_next.expired = 1'b1;
        end else begin
          t_next.ms = t_reg.ms + 15'h0001;
        end
      end else begin
        t_next.pre = t_reg.pre + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign expired = t_reg.expired;
endmodule
`default_nettype wire

// ==== hw/tpl_supervisor.sv ====
// Purpose: Phase order, phase loss and undervoltage supervisor with two relays
// Assumes: Pin inputs asynchronous; voltage codes come from logic on clk
// Notes:   TICK_CYCLES may be shortened for simulation
//
// Summary of operation
// RULE1: Watch phase order, phase loss and line voltages below 80 % of nominal.
// RULE2: Undervoltage clears only at trip threshold plus 5 % of nominal.
// RULE3: Both relays always carry the same command.
// RULE4: Relays energised when healthy, released on fault or lost supply.
// RULE5: Green indicator lit whenever supply is present.
// RULE6: Energise only with correct order, all phases, voltage in range.
// RULE7: Wrong phase order flashes red and keeps relays released.
// RULE8: Undervoltage trips after the set delay, then red lit steadily.
// RULE9: Phase loss trips at once with red lit steadily, no delay.
// RULE10: Relays return automatically once the fault is gone.
// RULE11: Red indicator follows fault diagnosis, not relay command.
// RULE12: Trip delay adjustable from 0.1 s to 20 s and honoured.
// RULE13: Nominal voltage selectable 200 V to 690 V, endpoints are absolute.
// RULE14: Without supply both indicators dark and relays released.
// RULE15: Undervoltage clearing early cancels the timer; next one restarts it.
`timescale 1ns/10ps
`default_nettype none
module tpl_supervisor #(
  parameter int TICK_CYCLES = tpl_pkg::TICK_CYCLES
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire tpl_pkg::tpl_pins_t       pins_in,
  input  wire tpl_pkg::tpl_volts_t      line_volts,
  input  wire logic [tpl_pkg::V_W-1:0]  nominal_line_voltage_setting,
  input  wire logic [tpl_pkg::MS_W-1:0] delay_setting_ms,
  output var  logic                     first_output_relay,
  output var  logic                     second_output_relay,
  output var  logic                     supply_led,
  output var  logic                     fault_led
);
  import tpl_pkg::*;

  typedef struct packed {
    tpl_pins_t  sync1;
    tpl_pins_t  sync2;
    logic [2:0] uv_band;
    logic       flash;
    logic       relay;
    logic       green;
    logic       red;
  } tpl_state_t;

  tpl_state_t s_reg;
  tpl_state_t s_next;

  logic [V_W-1:0]  un_sel;
  logic [MS_W-1:0] delay_sel;
  logic [2:0]      below;
  logic [2:0]      recover;
  logic [V_W-1:0]  v_line [3];
  logic            uv_any;
  logic            uv_trip;
  logic            flash_exp;
  logic            phase_loss;
  logic            order_bad;
  logic            healthy;
  logic            order_only;

  // ----------------------------------------------------------------
  // Settings clamp
  // ----------------------------------------------------------------
  // RULE13: clamp nominal voltage
  assign un_sel = (nominal_line_voltage_setting < UN_MIN_V) ? UN_MIN_V :
                  (nominal_line_voltage_setting > UN_MAX_V) ? UN_MAX_V : nominal_line_voltage_setting;
  // RULE12: clamp trip delay
  assign delay_sel = (delay_setting_ms < DELAY_MIN_MS) ? DELAY_MIN_MS :
                     (delay_setting_ms > DELAY_MAX_MS) ? DELAY_MAX_MS : delay_setting_ms;

  // ----------------------------------------------------------------
  // Per-line undervoltage compare
  // ----------------------------------------------------------------
  assign v_line[0] = line_volts.ab;
  assign v_line[1] = line_volts.bc;
  assign v_line[2] = line_volts.ca;

  for (genvar i = 0; i < 3; i++) begin : g_line
    logic [P_W-1:0] v_w;
    logic [P_W-1:0] un_w;
    assign v_w  = P_W'(v_line[i]);
    assign un_w = P_W'(un_sel);
    // RULE1: trip threshold compare
    assign below[i]   = (v_w * TRIP_V_MUL) < (un_w * TRIP_UN_MUL);
    // RULE2: recovery with hysteresis band
    assign recover[i] = (v_w * REC_V_MUL) >= (un_w * REC_UN_MUL);
  end

  // RULE8: any single line or all lines alike start the delay
  assign uv_any     = |s_reg.uv_band;
  assign phase_loss = ~&s_reg.sync2.phase_ok;
  assign order_bad  = ~s_reg.sync2.seq_ok;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // RULE15: timer runs only while undervoltage persists
  tpl_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_trip_timer (
    .clk      (clk),
    .nrst     (nrst),
    .run      (uv_any),
    .limit_ms (delay_sel),
    .expired  (uv_trip)
  );

  // Same timer reused as flash divider; one idle cycle per half period
  tpl_ms_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_flash_timer (
    .clk      (clk),
    .nrst     (nrst),
    .run      (order_bad & ~flash_exp),
    .limit_ms (FLASH_HALF_MS),
    .expired  (flash_exp)
  );

  // RULE6: healthy only with every condition met
  assign healthy = s_reg.sync2.supply & ~order_bad & ~phase_loss & ~uv_trip;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = pins_in;
    s_next.sync2 = s_reg.sync1;
    // RULE2: band set below trip, held until recovery
    s_next.uv_band = (s_reg.uv_band & ~recover) | below;
    if (!order_bad) begin
      s_next.flash = 1'b0;
    end else if (flash_exp) begin
      s_next.flash = ~s_reg.flash;
    end
    // RULE4: closed-circuit drive; RULE10: no latch, so recovery is automatic
    s_next.relay = healthy;
    // RULE5: green mirrors supply
    s_next.green = s_reg.sync2.supply;
    // RULE11: red from diagnosis; loss outranks order since order is meaningless then
    if (!s_reg.sync2.supply) begin
      // RULE14: dark without supply
      s_next.red = 1'b0;
    end else if (phase_loss) begin
      // RULE9: steady, no delay
      s_next.red = 1'b1;
    end else if (order_bad) begin
      // RULE7: flashing on wrong order
      s_next.red = s_reg.flash;
    end else begin
      // RULE8: steady after the delay
      s_next.red = uv_trip;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // RULE3: one register feeds both relays
  assign first_output_relay  = s_reg.relay;
  assign second_output_relay = s_reg.relay;
  assign supply_led          = s_reg.green;
  assign fault_led           = s_reg.red;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Wrong order alone sets the red pattern; loss or dark supply masks it
  assign order_only = s_reg.sync2.supply & ~phase_loss & order_bad;

  relays_equal_a: assert property (first_output_relay == second_output_relay) // RULE3
    else $error("relay commands differ");
  relay_cause_a: assert property (first_output_relay |-> $past(healthy)) // RULE6
    else $error("relay energised without healthy line");
  relay_drop_a: assert property (!s_reg.sync2.supply |=> !first_output_relay) // RULE4
    else $error("relay held without supply");
  green_supply_a: assert property (s_reg.sync2.supply |=> supply_led) // RULE5
    else $error("green dark with supply");
  dark_nosupply_a: assert property (!s_reg.sync2.supply |=> !supply_led && !fault_led) // RULE14
    else $error("indicator lit without supply");
  order_rest_a: assert property (order_bad |=> !first_output_relay) // RULE7
    else $error("relay energised on wrong order");
  // Window opens a cycle early so a loss ending at the toggle cannot fake a miss
  flash_toggle_a: assert property (order_only ##1 order_only && flash_exp ##1 order_only
                                   |=> fault_led != $past(fault_led, 2)) // RULE7
    else $error("red not flashing");
  loss_trip_a: assert property (s_reg.sync2.supply && phase_loss |=> fault_led && !first_output_relay) // RULE9
    else $error("phase loss not tripped at once");
  uv_cancel_a: assert property (!uv_any |=> !uv_trip) // RULE15
    else $error("trip timer not cancelled");
  uv_steady_a: assert property (s_reg.sync2.supply && !phase_loss && !order_bad && uv_trip
                                |=> fault_led && !first_output_relay) // RULE8
    else $error("undervoltage trip not shown");
  auto_reset_a: assert property (healthy |=> first_output_relay && !fault_led) // RULE10
    else $error("no automatic recovery");
  uv_band_a: assert property (below[0] |=> s_reg.uv_band[0]) // RULE1
    else $error("undervoltage not detected");
  red_no_relay_a: assert property (fault_led |-> !first_output_relay) // RULE6
    else $error("red lit with relays energised");
  // A fresh dip never trips at once, whatever the setting
  trip_wait_a: assert property ($rose(uv_any) |-> !uv_trip [*8]) // RULE12
    else $error("trip delay cut short");

  // Main scenarios

  healthy_c: cover property (!first_output_relay ##1 first_output_relay);
  trip_c: cover property (uv_any ##1 uv_trip);
  flash_c: cover property (order_bad && flash_exp);
  loss_c: cover property (phase_loss && fault_led);
  recover_c: cover property (uv_trip ##1 !uv_trip);
endmodule
`default_nettype wire

// ==== dv/tpl_mains_model.sv ====
// Purpose: Three-phase network model at the supervisor's measuring side
// Assumes: Bench changes the levels at the falling clock edge
// Notes:   A dead phase or absent supply reads zero volts on its lines
`timescale 1ns/10ps
`default_nettype none
module tpl_mains_model (
  input  wire logic                    supply_on,
  input  wire logic                    order_ok,
  input  wire logic [2:0]              phase_on,
  input  wire logic [tpl_pkg::V_W-1:0] volt_ab,
  input  wire logic [tpl_pkg::V_W-1:0] volt_rest,
  output var  tpl_pkg::tpl_pins_t      pins_in,
  output var  tpl_pkg::tpl_volts_t     line_volts
);
  import tpl_pkg::*;
  // Lost phase drags its lines to zero, so a loss also looks like undervoltage
  always_comb begin
    pins_in.supply   = supply_on;
    pins_in.seq_ok   = order_ok;
    pins_in.phase_ok = supply_on ? phase_on : 3'h0;
    line_volts.ab    = (supply_on & phase_on[0] & phase_on[1]) ? volt_ab : 10'h000;
    line_volts.bc    = (supply_on & phase_on[1] & phase_on[2]) ? volt_rest : 10'h000;
    line_volts.ca    = (supply_on & phase_on[2] & phase_on[0]) ? volt_rest : 10'h000;
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the line fault supervisor
// Assumes: TICK_CYCLES of 10, so one ms is ten cycles
// Notes:   Outputs read as {relay1, relay2, green, red}
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tpl_pkg::*;
  localparam int TICK = 10;
  logic            clk, nrst, sup, ord;
  logic [2:0]      ph;
  logic [V_W-1:0]  v_ab, v_rest, un;
  logic [MS_W-1:0] dly;
  tpl_pins_t       pins;
  tpl_volts_t      volts;
  logic            r1, r2, g, red, a;
  logic [3:0]      outs;
  int              n_fail, cmp_count, k;
  assign outs = {r1, r2, g, red};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  tpl_mains_model mains (.supply_on(sup), .order_ok(ord), .phase_on(ph), .volt_ab(v_ab),
    .volt_rest(v_rest), .pins_in(pins), .line_volts(volts));
  tpl_supervisor #(.TICK_CYCLES(TICK)) dut (.clk(clk), .nrst(nrst), .pins_in(pins),
    .line_volts(volts), .nominal_line_voltage_setting(un), .delay_setting_ms(dly),
    .first_output_relay(r1), .second_output_relay(r2), .supply_led(g), .fault_led(red));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic set_line(input logic s, input logic o, input logic [2:0] p, input logic [9:0] va,
                          input logic [9:0] vr);
    sup = s;
    ord = o;
    ph = p;
    v_ab = va;
    v_rest = vr;
  endtask
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short well past the expected run of about 13300 cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    nrst = 1'b0;
    un = 10'h190;
    dly = 15'h0000;
    set_line(1'b0, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(4);
    nrst = 1'b1;
    cyc(4);
    check("no_supply", outs, 4'h0);
    set_line(1'b1, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(4);
    check("healthy", outs, 4'hE);
    $display("test power_up done");
    for (int i = 0; i < 3; i++) begin
      set_line(1'b1, 1'b1, 3'h7 ^ (3'h1 << i), 10'h190, 10'h190);
      cyc(4);
      check("phase_loss", outs, 4'h3);
      set_line(1'b1, 1'b1, 3'h7, 10'h190, 10'h190);
      cyc(4);
      check("phase_back", outs, 4'hE);
    end
    $display("test phase_loss done");
    set_line(1'b1, 1'b0, 3'h7, 10'h190, 10'h190);
    cyc(4);
    a = red;
    k = 0;
    while (red === a && k < 3000) begin
      cyc(1);
      k++;
    end
    check("flash_edge", outs, {3'h1, ~a});
    cyc(1250);
    check("flash_start", outs, {3'h1, ~a});
    cyc(int'(FLASH_HALF_MS) * TICK);
    check("flash_toggle", outs, {3'h1, a});
    set_line(1'b1, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(4);
    check("order_back", outs, 4'hE);
    $display("test phase_order done");
    // Short dip then a fresh one: a timer left running would trip early
    set_line(1'b1, 1'b1, 3'h7, 10'h12C, 10'h190);
    cyc(600);
    set_line(1'b1, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(20);
    set_line(1'b1, 1'b1, 3'h7, 10'h13F, 10'h13F);
    cyc(950);
    check("uv_restart", outs, 4'hE);
    cyc(60);
    check("uv_trip", outs, 4'h3);
    set_line(1'b1, 1'b1, 3'h7, 10'h153, 10'h153);
    cyc(20);
    check("uv_hyst", outs, 4'h3);
    set_line(1'b1, 1'b1, 3'h7, 10'h154, 10'h154);
    cyc(20);
    check("uv_clear", outs, 4'hE);
    set_line(1'b1, 1'b1, 3'h7, 10'h140, 10'h140);
    cyc(1100);
    check("uv_edge", outs, 4'hE);
    $display("test undervoltage done");
    for (int i = 0; i < 2; i++) begin
      un = i ? 10'h064 : 10'h384;
      set_line(1'b1, 1'b1, 3'h7, i ? 10'h09F : 10'h230, i ? 10'h09F : 10'h230);
      cyc(1100);
      check("nominal_clamp", outs, i ? 4'h3 : 4'hE);
    end
    $display("test nominal_range done");
    un = 10'h190;
    dly = 15'h00C8;
    set_line(1'b1, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(10);
    set_line(1'b1, 1'b1, 3'h7, 10'h12C, 10'h12C);
    cyc(1950);
    check("delay_hold", outs, 4'hE);
    cyc(60);
    check("delay_trip", outs, 4'h3);
    set_line(1'b0, 1'b1, 3'h7, 10'h190, 10'h190);
    cyc(4);
    check("supply_gone", outs, 4'h0);
    $display("test delay_and_supply done");
    report_and_stop();
  end
endmodule
`default_nettype wire
